/* File: design/ptrdec_core.sv */
// pointer-op execution core with indexed, inherent and relative addressing
`timescale 1ns/1ns
module ptrdec_core
	import ptrdec_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [2:0]  opMode,
	input  wire logic [7:0]  accB,
	input  wire logic        intSel,
	input  wire logic [7:0]  intRdData,
	input  wire logic [7:0]  dataIn,
	output logic [15:0]      addr_q,
	output logic [7:0]       dataOut_q,
	output logic             dataOe_q,
	output logic             rdWrN_q,
	output logic [15:0]      indexReg_q,
	output logic [15:0]      stackPtr_q,
	output logic [15:0]      progCnt_q,
	output logic [7:0]       condCode_q,
	output logic             illegal_q
);
	typedef enum logic [2:0] {ST_FETCH, ST_ARG1, ST_ARG2, ST_EXE1, ST_EXE2, ST_EXE3} ptrdec_st_e;

	ptrdec_st_e  state_q;
	ptrdec_op_e  opKind;
	ptrdec_am_e  addrMode;
	ptrdec_op_e  curOp_q;
	ptrdec_am_e  curAm_q;
	logic [7:0]  opcode_q;
	logic [7:0]  arg1_q;
	logic [15:0] effAddr_q;
	logic [2:0]  modeSyncA_q;
	logic [2:0]  modeSyncB_q;
	logic [7:0]  dataSync_q;
	logic [7:0]  dataIn_q;
	logic        brTaken;
	logic [15:0] dispExt;
	logic [15:0] idxAddr;
	logic [1:0]  waitCnt_q;

	localparam logic [1:0] BUS_WAIT = 2'h2; // edges for read data to cross both input flops
	localparam logic [1:0] BUS_IDLE = 2'h0;
	localparam logic [1:0] BUS_STEP = 2'h1;

	// each bus cycle spans three clocks, so dataIn_q always belongs to addr_q;
	// trades speed for a data path that never sees a raw pin
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			waitCnt_q <= BUS_WAIT;
		end else if (waitCnt_q != BUS_IDLE) begin
			waitCnt_q <= waitCnt_q - BUS_STEP;
		end else begin
			waitCnt_q <= BUS_WAIT;
		end
	end

	// mode and data pins come from outside, two flops before use
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			modeSyncA_q <= '0;
			modeSyncB_q <= '0;
			dataSync_q  <= '0;
			dataIn_q    <= '0;
		end else begin
			modeSyncA_q <= opMode;
			modeSyncB_q <= modeSyncA_q;
			dataSync_q  <= dataIn;
			dataIn_q    <= dataSync_q;
		end
	end
	ptrdec_opdec u_opdec (
		.opcode   (dataIn_q),
		.opKind   (opKind),
		.addrMode (addrMode)
	);

	// indexed address: unsigned offset added with carry, index untouched
	assign idxAddr = indexReg_q + {8'h00, arg1_q};
	assign dispExt = {{8{arg1_q[7]}}, arg1_q};
	// only BRA (always) and BRN (never) are evaluated here; others use Z
	assign brTaken = (opcode_q == OP_BRA) ? 1'b1 :
			 (opcode_q == OP_BRN) ? 1'b0 : condCode_q[CC_Z] ^ opcode_q[0];

	// sequencer: fetch, operand bytes, then execute cycles
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q    <= ST_FETCH;
			curOp_q    <= OPK_NOP;
			curAm_q    <= AM_INH;
			opcode_q   <= '0;
			arg1_q     <= '0;
			effAddr_q  <= '0;
			progCnt_q  <= RST_VEC;
			indexReg_q <= '0;
			stackPtr_q <= RST_SP;
			condCode_q <= RST_CC;
			addr_q     <= RST_VEC;
			dataOut_q  <= '0;
			dataOe_q   <= 1'b0;
			rdWrN_q    <= 1'b1;
			illegal_q  <= 1'b0;
		end else begin
			dataOe_q <= 1'b0;
			rdWrN_q  <= 1'b1;
			if (waitCnt_q != BUS_IDLE) begin
				// bus cycle still settling through the input flops
			end else case (state_q)
				ST_FETCH: begin
					opcode_q  <= dataIn_q;
					curOp_q   <= opKind;
					curAm_q   <= addrMode;
					illegal_q <= (opKind == OPK_ILL);
					progCnt_q <= progCnt_q + ONE16;
					addr_q    <= progCnt_q + ONE16;
					// inherent ops skip operand fetch entirely
					if (addrMode == AM_INH) begin
						state_q <= ST_EXE1;
					end else if (addrMode == AM_BAD) begin
						state_q <= ST_FETCH;
					end else begin
						state_q <= ST_ARG1;
					end
				end
				ST_ARG1: begin
					arg1_q    <= dataIn_q;
					progCnt_q <= progCnt_q + ONE16;
					addr_q    <= progCnt_q + ONE16;
					if (curAm_q == AM_EXT) begin
						state_q <= ST_ARG2;
					end else begin
						state_q <= ST_EXE1;
					end
				end
				ST_ARG2: begin
					effAddr_q <= {arg1_q, dataIn_q};
					progCnt_q <= progCnt_q + ONE16;
					state_q   <= ST_EXE1;
				end
				ST_EXE1: begin
					state_q <= ST_FETCH;
					addr_q  <= progCnt_q;
					case (curOp_q)
						OPK_TSX, OPK_TXS, OPK_INS, OPK_DES,
						OPK_INX, OPK_DEX, OPK_ABX: begin
							// 3-cycle inherent: one idle cycle follows
							state_q <= ST_EXE3;
							addr_q  <= stackPtr_q;
						end
						OPK_PUSH_INDEX_OP: begin
							addr_q     <= stackPtr_q;
							dataOut_q  <= indexReg_q[7:0];
							dataOe_q   <= 1'b1;
							rdWrN_q    <= 1'b0;
							stackPtr_q <= stackPtr_q - ONE16;
							state_q    <= ST_EXE2;
						end
						OPK_PULL_INDEX_OP: begin
							stackPtr_q <= stackPtr_q + ONE16;
							addr_q     <= stackPtr_q + ONE16;
							state_q    <= ST_EXE2;
						end
						OPK_STX: begin
							effAddr_q <= (curAm_q == AM_IDX) ? idxAddr :
								     (curAm_q == AM_DIR) ? {8'h00, arg1_q} : effAddr_q;
							addr_q    <= (curAm_q == AM_IDX) ? idxAddr :
								     (curAm_q == AM_DIR) ? {8'h00, arg1_q} : effAddr_q;
							dataOut_q <= indexReg_q[15:8];
							dataOe_q  <= 1'b1;
							rdWrN_q   <= 1'b0;
							state_q   <= ST_EXE2;
						end
						OPK_BR: begin
							if (brTaken) begin
								progCnt_q <= progCnt_q + dispExt;
								addr_q    <= progCnt_q + dispExt;
							end
						end
						default: begin
						end
					endcase
				end
				ST_EXE2: begin
					state_q <= ST_FETCH;
					addr_q  <= progCnt_q;
					case (curOp_q)
						OPK_PUSH_INDEX_OP: begin
							addr_q     <= stackPtr_q;
							dataOut_q  <= indexReg_q[15:8];
							dataOe_q   <= 1'b1;
							rdWrN_q    <= 1'b0;
							stackPtr_q <= stackPtr_q - ONE16;
							state_q    <= ST_EXE3;
						end
						OPK_PULL_INDEX_OP: begin
							indexReg_q[15:8] <= dataIn_q;
							stackPtr_q <= stackPtr_q + ONE16;
							addr_q     <= stackPtr_q + ONE16;
							state_q    <= ST_EXE3;
						end
						OPK_STX: begin
							addr_q    <= effAddr_q + ONE16;
							dataOut_q <= indexReg_q[7:0];
							dataOe_q  <= 1'b1;
							rdWrN_q   <= 1'b0;
							condCode_q[CC_V] <= 1'b0;
							condCode_q[CC_N] <= indexReg_q[15];
							condCode_q[CC_Z] <= (indexReg_q == 16'h0000);
							// extra cycle puts the counter back on the bus
							state_q   <= ST_EXE3;
						end
						default: begin
						end
					endcase
				end
				ST_EXE3: begin
					state_q <= ST_FETCH;
					addr_q  <= progCnt_q;
					// transfer and step results commit on the last cycle, pull only its low byte; INX and DEX also update Z, other flags kept
					case (curOp_q)
						OPK_TXS: stackPtr_q <= indexReg_q - ONE16;
						OPK_TSX: indexReg_q <= stackPtr_q + ONE16;
						OPK_INS: stackPtr_q <= stackPtr_q + ONE16;
						OPK_DES: stackPtr_q <= stackPtr_q - ONE16;
						OPK_INX: begin
							indexReg_q       <= indexReg_q + ONE16;
							condCode_q[CC_Z] <= (indexReg_q == 16'hFFFF);
						end
						OPK_DEX: begin
							indexReg_q       <= indexReg_q - ONE16;
							condCode_q[CC_Z] <= (indexReg_q == ONE16);
						end
						OPK_ABX: indexReg_q <= indexReg_q + {8'h00, accB};
						OPK_PULL_INDEX_OP: indexReg_q[7:0] <= dataIn_q;
						default: begin
						end
					endcase
				end
				default: state_q <= ST_FETCH;
			endcase
			// internal reads are echoed on the bus only while the mode flops hold the showing mode, as they do from reset
			// only on settling edges, so an echo can never clobber a write
			if (waitCnt_q != BUS_IDLE && intSel && rdWrN_q && modeSyncB_q == MODE_SHOW) begin
				dataOut_q <= intRdData;
				dataOe_q  <= 1'b1;
			end
		end
	end
endmodule

/* File: design/ptrdec_pkg.sv */
// package for the pointer-op and addressing decode block
package ptrdec_pkg;
	// opcodes
	localparam logic [7:0] OP_TSX  = 8'h30;
	localparam logic [7:0] OP_INS  = 8'h31;
	localparam logic [7:0] OP_DES  = 8'h34;
	localparam logic [7:0] OP_TXS  = 8'h35;
	localparam logic [7:0] OP_PULL_INDEX_OP = 8'h38;
	localparam logic [7:0] OP_ABX  = 8'h3A;
	localparam logic [7:0] OP_PUSH_INDEX_OP = 8'h3C;
	localparam logic [7:0] OP_INX  = 8'h08;
	localparam logic [7:0] OP_DEX  = 8'h09;
	localparam logic [7:0] OP_STXD = 8'hDF;
	localparam logic [7:0] OP_STXI = 8'hEF;
	localparam logic [7:0] OP_STXE = 8'hFF;
	localparam logic [7:0] OP_BRA  = 8'h20;
	localparam logic [7:0] OP_BRN  = 8'h21;
	localparam logic [7:0] OP_NOP  = 8'h01;
	// branch group occupies 0x20..0x2F
	localparam logic [3:0] BR_HI_NIB = 4'h2;
	// condition code bit positions
	localparam int CC_C = 0;
	localparam int CC_V = 1;
	localparam int CC_Z = 2;
	localparam int CC_N = 3;
	// reset values
	localparam logic [15:0] RST_VEC = 16'h0000;
	localparam logic [15:0] RST_SP  = 16'h00FF;
	localparam logic [7:0]  RST_CC  = 8'hC0;
	localparam logic [7:0]  ONE8    = 8'h01;
	localparam logic [15:0] ONE16   = 16'h0001;
	localparam logic [15:0] TWO16   = 16'h0002;
	// operating mode in which internal reads show on the data bus
	localparam logic [2:0]  MODE_SHOW = 3'h0;
	// addressing modes
	typedef enum logic [2:0] {AM_INH, AM_IMM, AM_DIR, AM_IDX, AM_EXT, AM_REL, AM_BAD} ptrdec_am_e;
	// operations
	typedef enum logic [3:0] {
		OPK_NOP, OPK_TSX, OPK_TXS, OPK_INS, OPK_DES, OPK_INX, OPK_DEX, OPK_ABX,
		OPK_PUSH_INDEX_OP, OPK_PULL_INDEX_OP, OPK_STX, OPK_BR, OPK_ILL
	} ptrdec_op_e;
endpackage

/* File: design/ptrdec_opdec.sv */
// opcode decoder: operation and addressing mode from the first byte
`timescale 1ns/1ns
module ptrdec_opdec
	import ptrdec_pkg::*;
(
	input  wire logic [7:0] opcode,
	output ptrdec_op_e      opKind,
	output ptrdec_am_e      addrMode
);
	// only the first byte is looked at; later bytes never steer the decode
	always_comb begin
		opKind   = OPK_ILL;
		addrMode = AM_BAD;
		if (opcode[7:4] == BR_HI_NIB) begin
			opKind   = OPK_BR;
			addrMode = AM_REL;
		end else begin
			case (opcode)
				OP_NOP:  begin opKind = OPK_NOP;  addrMode = AM_INH; end
				OP_TSX:  begin opKind = OPK_TSX;  addrMode = AM_INH; end
				OP_TXS:  begin opKind = OPK_TXS;  addrMode = AM_INH; end
				OP_INS:  begin opKind = OPK_INS;  addrMode = AM_INH; end
				OP_DES:  begin opKind = OPK_DES;  addrMode = AM_INH; end
				OP_INX:  begin opKind = OPK_INX;  addrMode = AM_INH; end
				OP_DEX:  begin opKind = OPK_DEX;  addrMode = AM_INH; end
				OP_ABX:  begin opKind = OPK_ABX;  addrMode = AM_INH; end
				OP_PUSH_INDEX_OP: begin opKind = OPK_PUSH_INDEX_OP; addrMode = AM_INH; end
				OP_PULL_INDEX_OP: begin opKind = OPK_PULL_INDEX_OP; addrMode = AM_INH; end
				OP_STXD: begin opKind = OPK_STX;  addrMode = AM_DIR; end
				OP_STXI: begin opKind = OPK_STX;  addrMode = AM_IDX; end
				OP_STXE: begin opKind = OPK_STX;  addrMode = AM_EXT; end
				default: begin opKind = OPK_ILL;  addrMode = AM_BAD; end
			endcase
		end
	end
endmodule

/* File: sim/ptrdec_props.sv */
// concurrent checks on the pointer-op core ports
`timescale 1ns/1ns
module ptrdec_props
	import ptrdec_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [2:0]  opMode,
	input wire logic [7:0]  accB,
	input wire logic        intSel,
	input wire logic [7:0]  intRdData,
	input wire logic [7:0]  dataIn,
	input wire logic [15:0] addr_q,
	input wire logic [7:0]  dataOut_q,
	input wire logic        dataOe_q,
	input wire logic        rdWrN_q,
	input wire logic [15:0] indexReg_q,
	input wire logic [15:0] stackPtr_q,
	input wire logic [15:0] progCnt_q,
	input wire logic [7:0]  condCode_q,
	input wire logic        illegal_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// a write strobe, and the strobe one bus cycle of three clocks later
	sequence wrNow;
		dataOe_q && !rdWrN_q;
	endsequence
	sequence wrNext;
		##3 (dataOe_q && !rdWrN_q);
	endsequence
	a_write_rw_low: assert property (dataOe_q && !$past(intSel) |-> !rdWrN_q)
		else $error("drive without write strobe");
	a_write_pair: assert property (wrNow |-> wrNext or $past(dataOe_q && !rdWrN_q, 3))
		else $error("write bytes not paired");
	a_pair_adjacent: assert property (wrNow ##0 $past(dataOe_q && !rdWrN_q, 3) |->
		addr_q == 16'($past(addr_q, 3) + 16'h0001)
		|| addr_q == 16'($past(addr_q, 3) - 16'h0001))
		else $error("second byte not at neighbour address");
	a_sp_step: assert property ($changed(stackPtr_q) |-> stackPtr_q == 16'($past(stackPtr_q) + 16'h0001)
		|| stackPtr_q == 16'($past(stackPtr_q) - 16'h0001)
		|| stackPtr_q == 16'($past(indexReg_q) - 16'h0001))
		else $error("stack pointer moved oddly");
	a_cc_v_clear: assert property ($changed(condCode_q) |-> !condCode_q[CC_V])
		else $error("overflow flag set");
	a_internal_hidden: assert property (opMode != MODE_SHOW && $stable(opMode) [*4]
		|-> !(dataOe_q && rdWrN_q))
		else $error("internal read echoed");
	a_index_kept: assert property (dataOe_q |-> $stable(indexReg_q))
		else $error("index changed while storing");
	a_cc_top_ones: assert property (condCode_q[7:6] == 2'h3)
		else $error("unused flag bits not ones");
endmodule
bind ptrdec_core ptrdec_props u_props (.clk(clk), .nrst(nrst), .opMode(opMode), .accB(accB),
	.intSel(intSel), .intRdData(intRdData), .dataIn(dataIn), .addr_q(addr_q),
	.dataOut_q(dataOut_q), .dataOe_q(dataOe_q), .rdWrN_q(rdWrN_q), .indexReg_q(indexReg_q),
	.stackPtr_q(stackPtr_q), .progCnt_q(progCnt_q), .condCode_q(condCode_q),
	.illegal_q(illegal_q));

/* File: sim/ptrdec_mem.sv */
// program and data memory on the core bus
`timescale 1ns/1ns
module ptrdec_mem (
	input  wire logic        clk,
	input  wire logic [15:0] addr,
	input  wire logic        rdWrN,
	input  wire logic        wrEn,
	input  wire logic [7:0]  wrData,
	output logic      [7:0]  rdData
);
	logic [7:0] mem [0:65535];
	// written byte lands at the strobing edge
	always @(posedge clk) begin
		if (wrEn && !rdWrN) begin
			mem[addr] <= wrData;
		end
	end
	// while rdWrN is low the read port shows inverted data, not a stale copy
	assign rdData = rdWrN ? mem[addr] : ~mem[addr];
endmodule

/* File: sim/pointer_op_and_addressing_decode_bench.sv */
// self-checking bench for the pointer-op core
`timescale 1ns/1ns
module pointer_op_and_addressing_decode_bench;
	import ptrdec_pkg::*;
	logic        clk, nrst, intSel, dataOe, rdWrN, illegal;
	logic [2:0]  opMode;
	logic [7:0]  accB, intRdData, dataIn, dataOut, cc, b;
	logic [15:0] addr, xReg, sp, pc, x0;
	logic [23:0] expQ [$];
	int          failures, n_tests, cyc, wrCnt;
	ptrdec_core u_dut (.clk(clk), .nrst(nrst), .opMode(opMode), .accB(accB), .intSel(intSel),
		.intRdData(intRdData), .dataIn(dataIn), .addr_q(addr), .dataOut_q(dataOut),
		.dataOe_q(dataOe), .rdWrN_q(rdWrN), .indexReg_q(xReg), .stackPtr_q(sp),
		.progCnt_q(pc), .condCode_q(cc), .illegal_q(illegal));
	ptrdec_mem u_mem (.clk(clk), .addr(addr), .rdWrN(rdWrN), .wrEn(dataOe), .wrData(dataOut),
		.rdData(dataIn));
	always #2 clk = ~clk;
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic cmpWr(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t write got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmpReg(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
		end
	endtask
	// hang guard, the program settles in well under two hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			final_report();
		end
	end
	// every write cycle is matched against the oldest expectation, or against all ones once none is left
	always @(posedge clk) begin
		if (nrst && dataOe === 1'b1 && rdWrN === 1'b0) begin
			wrCnt++;
			if (expQ.size() == 0) cmpWr({addr, dataOut}, 24'hFFFFFF);
			else cmpWr({addr, dataOut}, expQ.pop_front());
		end
	end
	initial begin
		clk = 0; nrst = 0; intSel = 0; intRdData = 8'h00; opMode = 3'h0; accB = 8'h00;
		void'($urandom(40688));
		b = 8'($urandom);
		for (int i = 0; i < 65536; i++) u_mem.mem[i] = OP_NOP;
		// transfers, push, indexed store, pull, add B, branch to self
		u_mem.mem[0] = OP_TSX; u_mem.mem[1] = OP_TXS; u_mem.mem[2] = OP_PUSH_INDEX_OP;
		u_mem.mem[3] = OP_STXI; u_mem.mem[4] = 8'h05; u_mem.mem[5] = OP_PULL_INDEX_OP;
		u_mem.mem[6] = OP_ABX; u_mem.mem[7] = OP_BRA; u_mem.mem[8] = 8'hFE;
		x0 = 16'(RST_SP + ONE16);
		expQ.push_back({RST_SP, x0[7:0]});
		expQ.push_back({16'(RST_SP - ONE16), x0[15:8]});
		expQ.push_back({16'(x0 + 16'h0005), x0[15:8]});
		expQ.push_back({16'(x0 + 16'h0006), x0[7:0]});
		repeat (20) @(posedge clk);
		#1 nrst = 1;
		accB = b;
		opMode = 3'(1 + $urandom % 7);
		while (wrCnt < 4) @(posedge clk);
		$display("test writes done");
		for (int i = 0; i < 100 && xReg !== 16'(x0 + {8'h00, b}); i++) @(posedge clk);
		#1 cmpReg(xReg, 16'(x0 + {8'h00, b}));
		cmpReg(sp, RST_SP);
		cmpReg({8'h00, cc}, {8'h00, RST_CC});
		cmpReg({15'h0000, illegal}, 16'h0000);
		$display("test registers done");
		// internal reads shown in mode 0, hidden in one other mode picked at random
		intRdData = 8'($urandom);
		intSel = 1;
		opMode = MODE_SHOW;
		for (int i = 0; i < 12 && !(dataOe === 1'b1 && rdWrN === 1'b1); i++) begin
			@(posedge clk);
			#1;
		end
		cmpReg({15'h0000, dataOe}, 16'h0001);
		cmpReg({8'h00, dataOut}, {8'h00, intRdData});
		opMode = 3'(1 + $urandom % 7);
		repeat (5) @(posedge clk);
		repeat (6) begin
			@(posedge clk);
			#1 cmpReg({15'h0000, dataOe}, 16'h0000);
		end
		intSel = 0;
		repeat (20) @(posedge clk);
		cmpReg(16'(wrCnt), 16'h0004);
		$display("test echo done");
		final_report();
	end
endmodule
